/* verilog/dpsc_map.svh */
// Purpose: Register offsets, field positions, reset values for the DSCP/snoop control bank
// Assumes: Printed offsets are word indices; APB byte address is four times the index
// Notes: Definitions only
`ifndef DPSC_MAP_SVH
`define DPSC_MAP_SVH

// ----------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------
`define DPSC_IDX_MAP_38_39 12'h035c
`define DPSC_IDX_MAP_3A_3B 12'h035d
`define DPSC_IDX_MAP_3C_3D 12'h035e
`define DPSC_IDX_MAP_3E_3F 12'h035f
`define DPSC_IDX_GLOBAL 12'h0370
`define DPSC_IDX_WRED 12'h0378

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DPSC_ODD_HI 6
`define DPSC_ODD_LO 4
`define DPSC_EVEN_HI 2
`define DPSC_EVEN_LO 0
`define DPSC_BIT_IGMP_EN 6
`define DPSC_BIT_MLD_OPT 3
`define DPSC_BIT_MLD_EN 2
`define DPSC_BIT_SNIFF_AND 0
`define DPSC_RED_HI 5
`define DPSC_RED_LO 4
`define DPSC_YEL_HI 3
`define DPSC_YEL_LO 2
`define DPSC_GRN_HI 1
`define DPSC_GRN_LO 0

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define DPSC_RST_MAP 8'h00
`define DPSC_RST_GLOBAL 8'h00
`define DPSC_RST_WRED 8'h39
`define DPSC_MASK_MAP 8'h77
`define DPSC_MASK_GLOBAL 8'h4d
`define DPSC_MASK_WRED 8'h3f

// ----------------------------------------------------------------
// IPv6 next header codes and mapped DSCP base
// ----------------------------------------------------------------
`define DPSC_NH_HOP 8'h00
`define DPSC_NH_ICMP 8'h01
`define DPSC_NH_ICMPV6 8'h3a
`define DPSC_NH_ROUTE 8'h2b
`define DPSC_NH_FRAG 8'h2c
`define DPSC_NH_ESP 8'h32
`define DPSC_NH_AH 8'h33
`define DPSC_NH_DEST 8'h3c
`define DPSC_DSCP_BASE 6'h38

`endif

/* verilog/dpsc_pkg.sv */
// Purpose: Shared types of the DSCP/snoop control bank
// Assumes: Included map header supplies all numbers
// Notes: Types only
`include "dpsc_map.svh"
package dpsc_pkg;
  typedef struct packed {
    logic [5:0] dscp;
    logic is_ipv4;
    logic is_igmp;
    logic is_ipv6;
    logic [7:0] next_hdr;
    logic [7:0] hop_next_hdr;
    logic src_match;
    logic dst_match;
  } dpsc_frame_type;

  typedef struct packed {
    logic [2:0] prio;
    logic prio_hit;
    logic to_host;
    logic sniff;
  } dpsc_verdict_type;

  typedef enum logic [1:0] {
    DPSC_IDLE = 2'b00,
    DPSC_ACCESS = 2'b01
  } dpsc_apb_state_type;
endpackage

/* verilog/dpsc_prio_pair.sv */
// Purpose: One DSCP priority mapping register holding an even and an odd code
// Assumes: Write strobe from the APB decoder in the same clock
// Notes: Reserved bits 7 and 3 are never stored
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.svh"
module dpsc_prio_pair (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  output logic [2:0] even_prio_o,
  output logic [2:0] odd_prio_o
);
  import dpsc_pkg::*;
  logic [7:0] map_r;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      map_r <= `DPSC_RST_MAP; // [R03]
    end else if (ce_i && wr_i) begin
      map_r <= wdata_i & `DPSC_MASK_MAP; // [R14]
    end
  end

  assign rdata_o = map_r;
  assign odd_prio_o = map_r[`DPSC_ODD_HI:`DPSC_ODD_LO]; // [R01]
  assign even_prio_o = map_r[`DPSC_EVEN_HI:`DPSC_EVEN_LO]; // [R02]
endmodule // dpsc_prio_pair
`default_nettype wire

/* verilog/dpsc_ctrl.sv */
// Purpose: DSCP 0x38-0x3F priority map, snooping and sniff filter controls, WRED colour map
// Assumes: Frame descriptor inputs come from classifier logic on mclk_i
// Notes: APB slave, zero wait states, PSLVERR on unmapped addresses
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.svh"

// Functional notes
// [R01] Odd DSCP 0x39..0x3F takes priority from bits 6:4 of its map register.
// [R02] Even DSCP 0x38..0x3E takes priority from bits 2:0 of its map register.
// [R03] Priority fields reset to zero; bits 7 and 3 read zero.
// [R04] IGMP enable bit 6 sends every IGMP packet to the host port.
// [R05] MLD enable bit 2 sends every MLD packet to the host port.
// [R06] Option set: match next header 43,44,50,51,60, also behind hop-by-hop.
// [R07] Option clear: match next header 1 or 58, also behind hop-by-hop.
// [R08] Sniff select set: sniff only when source and destination both match.
// [R09] Sniff select clear: sniff when source or destination matches.
// [R10] Red DSCP field bits 5:4, read-write, resets to 11b.
// [R11] Yellow DSCP field bits 3:2, read-write, resets to 10b.
// [R12] Green DSCP field bits 1:0, read-write, resets to 01b.
// [R13] Software must also set per-port ingress mirroring to activate mirroring.
// [R14] Reserved bits ignore writes and read zero.
module dpsc_ctrl #(
  parameter int unsigned ADDR_W = 14
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [ADDR_W-1:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic frame_valid_i,
  input wire dpsc_pkg::dpsc_frame_type frame_i,
  output logic verdict_valid_o,
  output dpsc_pkg::dpsc_verdict_type verdict_o,
  output logic [1:0] red_dscp_o,
  output logic [1:0] yellow_dscp_o,
  output logic [1:0] green_dscp_o
);
  import dpsc_pkg::*;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] idx_w;
  logic aligned_w;
  logic setup_w;
  logic [3:0] sel_map_w;
  logic sel_glb_w;
  logic sel_wred_w;
  logic hit_w;
  logic wr_en_w;
  dpsc_apb_state_type st_r;
  dpsc_apb_state_type st_nxt;

  assign idx_w = {2'b00, paddr_i[ADDR_W-1:2]};
  assign aligned_w = (paddr_i[1:0] == 2'b00);
  assign setup_w = psel_i && !penable_i;
  assign sel_map_w[0] = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_MAP_38_39));
  assign sel_map_w[1] = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_MAP_3A_3B));
  assign sel_map_w[2] = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_MAP_3C_3D));
  assign sel_map_w[3] = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_MAP_3E_3F));
  assign sel_glb_w = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_GLOBAL));
  assign sel_wred_w = aligned_w && (idx_w == ADDR_W'(`DPSC_IDX_WRED));
  assign hit_w = (|sel_map_w) || sel_glb_w || sel_wred_w;
  // Writes land at the access edge, where the master samples ready high, so a
  // transfer that a master abandons before that edge leaves no trace
  assign wr_en_w = ce_i && psel_i && penable_i && (st_r == DPSC_ACCESS) && pwrite_i && hit_w;

  always_comb begin
    st_nxt = DPSC_IDLE;
    case (st_r)
      DPSC_IDLE: st_nxt = setup_w ? DPSC_ACCESS : DPSC_IDLE;
      DPSC_ACCESS: st_nxt = setup_w ? DPSC_ACCESS : DPSC_IDLE;
      default: st_nxt = DPSC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0] map_rd_w [4];
  logic [2:0] even_prio_w [4];
  logic [2:0] odd_prio_w [4];
  logic [7:0] glb_r;
  logic [7:0] wred_r;

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_map
      dpsc_prio_pair u_pair (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .wr_i(wr_en_w && sel_map_w[gi]),
        .wdata_i(pwdata_i[7:0]),
        .rdata_o(map_rd_w[gi]),
        .even_prio_o(even_prio_w[gi]),
        .odd_prio_o(odd_prio_w[gi])
      );
    end
  endgenerate

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      glb_r <= `DPSC_RST_GLOBAL;
      wred_r <= `DPSC_RST_WRED; // [R10] [R11] [R12]
    end else if (ce_i) begin
      if (wr_en_w && sel_glb_w) begin
        glb_r <= pwdata_i[7:0] & `DPSC_MASK_GLOBAL; // [R14]
      end
      if (wr_en_w && sel_wred_w) begin
        wred_r <= pwdata_i[7:0] & `DPSC_MASK_WRED; // [R14]
      end
    end
  end

  // ----------------------------------------------------------------
  // Read mux and APB answer
  // ----------------------------------------------------------------
  logic [7:0] rd_byte_w;
  assign rd_byte_w = sel_map_w[0] ? map_rd_w[0] :
                     sel_map_w[1] ? map_rd_w[1] :
                     sel_map_w[2] ? map_rd_w[2] :
                     sel_map_w[3] ? map_rd_w[3] :
                     sel_glb_w ? glb_r :
                     sel_wred_w ? wred_r : 8'h00;

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= DPSC_IDLE;
      prdata_o <= 32'h0000_0000;
      pready_o <= 1'b0;
      pslverr_o <= 1'b0;
    end else if (ce_i) begin
      st_r <= st_nxt;
      pready_o <= setup_w;
      pslverr_o <= setup_w && !hit_w;
      prdata_o <= (setup_w && !pwrite_i) ? {24'h00_0000, rd_byte_w} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Classification
  // ----------------------------------------------------------------
  logic igmp_en_w;
  logic mld_en_w;
  logic mld_opt_w;
  logic sniff_and_w;
  logic in_range_w;
  logic [1:0] pair_w;
  logic [2:0] prio_w;
  logic ext_nh_w;
  logic ext_hop_w;
  logic icmp_nh_w;
  logic icmp_hop_w;
  logic hop_w;
  logic mld_match_w;
  logic to_host_w;
  logic sniff_w;
  localparam logic [7:0] WRED_RST = `DPSC_RST_WRED;

  assign igmp_en_w = glb_r[`DPSC_BIT_IGMP_EN];
  assign mld_en_w = glb_r[`DPSC_BIT_MLD_EN];
  assign mld_opt_w = glb_r[`DPSC_BIT_MLD_OPT];
  assign sniff_and_w = glb_r[`DPSC_BIT_SNIFF_AND];

  assign in_range_w = (frame_i.dscp[5:3] == 3'(`DPSC_DSCP_BASE >> 3));
  assign pair_w = frame_i.dscp[2:1];
  assign prio_w = frame_i.dscp[0] ? odd_prio_w[pair_w] : even_prio_w[pair_w]; // [R01] [R02]

  assign ext_nh_w = (frame_i.next_hdr == `DPSC_NH_ROUTE) || (frame_i.next_hdr == `DPSC_NH_FRAG) ||
                    (frame_i.next_hdr == `DPSC_NH_ESP) || (frame_i.next_hdr == `DPSC_NH_AH) ||
                    (frame_i.next_hdr == `DPSC_NH_DEST);
  assign ext_hop_w = (frame_i.hop_next_hdr == `DPSC_NH_ROUTE) || (frame_i.hop_next_hdr == `DPSC_NH_FRAG) ||
                     (frame_i.hop_next_hdr == `DPSC_NH_ESP) || (frame_i.hop_next_hdr == `DPSC_NH_AH) ||
                     (frame_i.hop_next_hdr == `DPSC_NH_DEST);
  assign icmp_nh_w = (frame_i.next_hdr == `DPSC_NH_ICMP) || (frame_i.next_hdr == `DPSC_NH_ICMPV6);
  assign icmp_hop_w = (frame_i.hop_next_hdr == `DPSC_NH_ICMP) || (frame_i.hop_next_hdr == `DPSC_NH_ICMPV6);
  assign hop_w = (frame_i.next_hdr == `DPSC_NH_HOP);
  assign mld_match_w = mld_opt_w ? (ext_nh_w || (hop_w && ext_hop_w)) // [R06]
                                 : (icmp_nh_w || (hop_w && icmp_hop_w)); // [R07]
  assign to_host_w = (igmp_en_w && frame_i.is_ipv4 && frame_i.is_igmp) || // [R04]
                     (mld_en_w && frame_i.is_ipv6 && mld_match_w); // [R05]
  // Sniff flag is only the global filter; per-port mirror enables gate it downstream
  assign sniff_w = sniff_and_w ? (frame_i.src_match && frame_i.dst_match) // [R08] [R13]
                               : (frame_i.src_match || frame_i.dst_match); // [R09]

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      verdict_valid_o <= 1'b0;
      verdict_o <= '0;
      red_dscp_o <= WRED_RST[`DPSC_RED_HI:`DPSC_RED_LO];
      yellow_dscp_o <= WRED_RST[`DPSC_YEL_HI:`DPSC_YEL_LO];
      green_dscp_o <= WRED_RST[`DPSC_GRN_HI:`DPSC_GRN_LO];
    end else if (ce_i) begin
      verdict_valid_o <= frame_valid_i;
      verdict_o.prio <= in_range_w ? prio_w : 3'b000;
      verdict_o.prio_hit <= in_range_w;
      verdict_o.to_host <= to_host_w;
      verdict_o.sniff <= sniff_w;
      red_dscp_o <= wred_r[`DPSC_RED_HI:`DPSC_RED_LO]; // [R10]
      yellow_dscp_o <= wred_r[`DPSC_YEL_HI:`DPSC_YEL_LO]; // [R11]
      green_dscp_o <= wred_r[`DPSC_GRN_HI:`DPSC_GRN_LO]; // [R12]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_odd_prio;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && in_range_w && frame_i.dscp[0]) |=> (verdict_o.prio == $past(map_rd_w[pair_w][`DPSC_ODD_HI:`DPSC_ODD_LO]));
  endproperty
  a_odd_prio: assert property (p_odd_prio) else $error("odd dscp priority wrong"); // [R01]

  property p_even_prio;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && in_range_w && !frame_i.dscp[0]) |=> (verdict_o.prio == $past(map_rd_w[pair_w][`DPSC_EVEN_HI:`DPSC_EVEN_LO]));
  endproperty
  a_even_prio: assert property (p_even_prio) else $error("even dscp priority wrong"); // [R02]

  property p_map_rsvd;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ((map_rd_w[0] | map_rd_w[1] | map_rd_w[2] | map_rd_w[3]) & ~`DPSC_MASK_MAP) == 8'h00;
  endproperty
  a_map_rsvd: assert property (p_map_rsvd) else $error("map reserved bit set"); // [R03]

  property p_igmp;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && frame_i.is_ipv4 && frame_i.is_igmp && !frame_i.is_ipv6) |=> (verdict_o.to_host == $past(igmp_en_w));
  endproperty
  a_igmp: assert property (p_igmp) else $error("igmp host forward wrong"); // [R04]

  property p_mld;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && frame_i.is_ipv6 && !frame_i.is_ipv4 && icmp_nh_w && !mld_opt_w)
      |=> (verdict_o.to_host == $past(mld_en_w));
  endproperty
  a_mld: assert property (p_mld) else $error("mld host forward wrong"); // [R05] [R07]

  property p_mld_opt;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && mld_en_w && mld_opt_w && frame_i.is_ipv6 && hop_w && ext_hop_w) |=> verdict_o.to_host;
  endproperty
  a_mld_opt: assert property (p_mld_opt) else $error("mld option match missed"); // [R06]

  property p_sniff;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && (frame_i.src_match != frame_i.dst_match)) |=> (verdict_o.sniff == !$past(sniff_and_w));
  endproperty
  a_sniff: assert property (p_sniff) else $error("sniff filter wrong"); // [R08] [R09]

  property p_wred_out;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && $stable(wred_r)) |=> ({red_dscp_o, yellow_dscp_o, green_dscp_o} == $past(wred_r[5:0]));
  endproperty
  a_wred_out: assert property (p_wred_out) else $error("wred outputs wrong"); // [R10] [R11] [R12]

  property p_rsvd_read;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (glb_r[7] == 1'b0) && (glb_r[5:4] == 2'b00) && (glb_r[1] == 1'b0) && (wred_r[7:6] == 2'b00);
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("reserved bit set"); // [R14]

  // ----------------------------------------------------------------
  // Write path, bus answer and verdict checks
  // ----------------------------------------------------------------
  property p_map_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_en_w && sel_map_w[0]) |=> (map_rd_w[0] == ($past(pwdata_i[7:0]) & `DPSC_MASK_MAP));
  endproperty
  a_map_write: assert property (p_map_write) else $error("map write not stored"); // [R01] [R02] [R14]

  property p_glb_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_en_w && sel_glb_w) |=> (glb_r == ($past(pwdata_i[7:0]) & `DPSC_MASK_GLOBAL));
  endproperty
  a_glb_write: assert property (p_glb_write) else $error("global write not stored"); // [R04] [R05] [R14]

  property p_wred_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (wr_en_w && sel_wred_w) |=> (wred_r == ($past(pwdata_i[7:0]) & `DPSC_MASK_WRED));
  endproperty
  a_wred_write: assert property (p_wred_write) else $error("wred write not stored"); // [R10] [R11] [R12] [R14]

  property p_no_setup_write;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (psel_i && !penable_i) |=> ($stable(glb_r) && $stable(wred_r) && $stable(map_rd_w[0]));
  endproperty
  a_no_setup_write: assert property (p_no_setup_write) else $error("register changed in setup cycle");

  property p_err_refuse;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && setup_w && !hit_w) |=> (pready_o && pslverr_o && (prdata_o == 32'h0000_0000));
  endproperty
  a_err_refuse: assert property (p_err_refuse) else $error("unmapped access not refused"); // [R14]

  property p_ready_once;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && pready_o) |=> !pready_o;
  endproperty
  a_ready_once: assert property (p_ready_once) else $error("ready held too long");

  property p_prio_range;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && !in_range_w) |=> ((verdict_o.prio == 3'b000) && !verdict_o.prio_hit);
  endproperty
  a_prio_range: assert property (p_prio_range) else $error("priority outside mapped range"); // [R01] [R02]

  property p_verdict_valid;
    @(posedge mclk_i) disable iff (!rst_n_i)
    ce_i |=> (verdict_valid_o == $past(frame_valid_i));
  endproperty
  a_verdict_valid: assert property (p_verdict_valid) else $error("verdict valid misaligned");

  property p_host_off;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && !igmp_en_w && !mld_en_w) |=> !verdict_o.to_host;
  endproperty
  a_host_off: assert property (p_host_off) else $error("host forward while snooping off"); // [R04] [R05]

  property p_opt_clear_ext;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && mld_en_w && !mld_opt_w && frame_i.is_ipv6 && !frame_i.is_ipv4 && ext_nh_w)
      |=> !verdict_o.to_host;
  endproperty
  a_opt_clear_ext: assert property (p_opt_clear_ext) else $error("mld option ignored"); // [R06] [R07]

  property p_sniff_both;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && frame_i.src_match && frame_i.dst_match) |=> verdict_o.sniff;
  endproperty
  a_sniff_both: assert property (p_sniff_both) else $error("sniff missed on both ports"); // [R08] [R09]

  property p_sniff_none;
    @(posedge mclk_i) disable iff (!rst_n_i)
    (ce_i && !frame_i.src_match && !frame_i.dst_match) |=> !verdict_o.sniff;
  endproperty
  a_sniff_none: assert property (p_sniff_none) else $error("sniff without any port match"); // [R08] [R09]
endmodule // dpsc_ctrl
`default_nettype wire

/* dv/dscp_priority_snoop_ctrl_tb.sv */
// Purpose: Self-checking bench for the DSCP priority map, snooping, sniff filter and WRED colour bank
// Assumes: APB answer in the access phase; verdict one cycle after each descriptor
// Notes: Bus answers are taken at the rising edge that samples ready; verdicts at the falling edge
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_map.svh"
module dscp_priority_snoop_ctrl_tb;
  import dpsc_pkg::*;
  localparam logic [13:0] ADDRS [6] = '{{`DPSC_IDX_MAP_38_39, 2'b00}, {`DPSC_IDX_MAP_3A_3B, 2'b00},
    {`DPSC_IDX_MAP_3C_3D, 2'b00}, {`DPSC_IDX_MAP_3E_3F, 2'b00}, {`DPSC_IDX_GLOBAL, 2'b00}, {`DPSC_IDX_WRED, 2'b00}};
  localparam logic [31:0] RSTV [6] = '{32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
    32'h0000_0000, 32'h0000_0039};
  localparam logic [31:0] MASK [6] = '{32'h0000_0077, 32'h0000_0077, 32'h0000_0077, 32'h0000_0077,
    32'h0000_004d, 32'h0000_003f};
  localparam int NHS [8] = '{1, 58, 43, 44, 50, 51, 60, 6};
  logic mclk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic ce_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [13:0] paddr_i = 14'h0000;
  logic [31:0] pwdata_i = 32'h0000_0000;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic frame_valid_i = 1'b0;
  dpsc_frame_type frame_i = '0;
  logic verdict_valid_o;
  dpsc_verdict_type verdict_o;
  logic [1:0] red_dscp_o;
  logic [1:0] yellow_dscp_o;
  logic [1:0] green_dscp_o;
  int n_mismatch = 0;
  int total_checks = 0;

  always #5 mclk_i = ~mclk_i;

  dpsc_ctrl #(.ADDR_W(14)) u_dpsc_ctrl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .frame_valid_i(frame_valid_i), .frame_i(frame_i),
    .verdict_valid_o(verdict_valid_o), .verdict_o(verdict_o), .red_dscp_o(red_dscp_o),
    .yellow_dscp_o(yellow_dscp_o), .green_dscp_o(green_dscp_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic results();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Entered just after a rising edge; leaves one idle edge so psel is never driven twice in a step
  task automatic apb(input logic wr, input logic [13:0] a, input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= wd;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    // Request stands until the rising edge that samples ready high; answer taken at that edge
    for (n = 0; n < 20; n++) begin
      @(posedge mclk_i);
      if (pready_o === 1'b1) break;
    end
    if (n == 20) begin
      n_mismatch++;
      results();
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask

  task automatic wreg(input logic [13:0] a, input logic [31:0] wd);
    logic [31:0] rd;
    logic err;
    apb(1'b1, a, wd, rd, err);
  endtask

  task automatic frame(input dpsc_frame_type f, output dpsc_verdict_type v, output logic vld);
    frame_valid_i <= 1'b1;
    frame_i <= f;
    @(posedge mclk_i);
    frame_valid_i <= 1'b0;
    @(negedge mclk_i);
    v = verdict_o;
    vld = verdict_valid_o;
    @(posedge mclk_i);
  endtask

  function automatic logic in_set(input logic opt, input int v);
    return opt ? (v == 43 || v == 44 || v == 50 || v == 51 || v == 60) : (v == 1 || v == 58);
  endfunction

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] rd;
    logic err;
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ADDRS[k], 32'h0000_0000, rd, err);
      chk("reset value", rd, RSTV[k]);
    end
    chk("wred ports at reset", 32'({red_dscp_o, yellow_dscp_o, green_dscp_o}), 32'h0000_0039);
    for (int k = 0; k < 6; k++) begin
      wreg(ADDRS[k], 32'hffff_ffff);
      apb(1'b0, ADDRS[k], 32'h0000_0000, rd, err);
      chk("writable bits", rd, MASK[k]);
    end
    wreg(ADDRS[5], 32'h0000_001b);
    @(negedge mclk_i);
    chk("wred ports", 32'({red_dscp_o, yellow_dscp_o, green_dscp_o}), 32'h0000_001b);
    @(posedge mclk_i);
    apb(1'b0, 14'h0d80, 32'h0000_0000, rd, err);
    chk("unmapped read", {err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, 14'h0d71, 32'h0000_0000, rd, err);
    chk("unaligned write refused", 32'(err), 32'h0000_0001);
    apb(1'b0, ADDRS[0], 32'h0000_0000, rd, err);
    chk("map kept after refusal", rd, 32'h0000_0077);
  endtask

  // Second reset in mid-run, after fields were written: all must return to reset values
  task automatic t_reset();
    logic [31:0] rd;
    logic err;
    rst_n_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    for (int k = 0; k < 6; k++) begin
      apb(1'b0, ADDRS[k], 32'h0000_0000, rd, err);
      chk("value after reset", rd, RSTV[k]);
    end
    chk("wred ports reset", 32'({red_dscp_o, yellow_dscp_o, green_dscp_o}), 32'h0000_0039);
  endtask

  task automatic t_prio();
    dpsc_frame_type f;
    dpsc_verdict_type v;
    logic vld;
    logic [2:0] e;
    for (int k = 0; k < 4; k++) begin
      // Reserved bits set on purpose: they must not leak into priorities
      wreg(ADDRS[k], {24'h00_0000, 1'b1, 3'(6 - k), 1'b1, 3'(k + 1)});
    end
    for (int c = 0; c < 9; c++) begin
      f = '0;
      f.dscp = (c == 8) ? 6'h37 : 6'(8'h38 + c);
      frame(f, v, vld);
      e = (c == 8) ? 3'h0 : (c % 2 == 1) ? 3'(6 - c / 2) : 3'(c / 2 + 1);
      chk("prio", 32'({vld, v.prio, v.prio_hit}), 32'({1'b1, e, c != 8}));
    end
  endtask

  task automatic t_snoop();
    dpsc_frame_type f;
    dpsc_verdict_type v;
    logic vld;
    for (int m = 0; m < 4; m++) begin
      wreg(ADDRS[4], m[1] ? 32'h0000_0040 : 32'h0000_0000);
      f = '0;
      f.is_ipv4 = 1'b1;
      f.is_igmp = m[0];
      frame(f, v, vld);
      chk("igmp to host", 32'(v.to_host), 32'(m[1] & m[0]));
    end
    for (int m = 0; m < 8; m++) begin
      wreg(ADDRS[4], 32'({m[2], m[1], 2'b00}));
      for (int i = 0; i < 8; i++) begin
        f = '0;
        f.is_ipv6 = 1'b1;
        f.next_hdr = m[0] ? 8'h00 : 8'(NHS[i]);
        // Direct case carries a listed hop value to catch a hop test that ignores next header zero
        f.hop_next_hdr = m[0] ? 8'(NHS[i]) : 8'h01;
        frame(f, v, vld);
        chk("mld to host", 32'(v.to_host), 32'(m[1] & in_set(m[2], NHS[i])));
      end
    end
  endtask

  // The sniff output is the global filter alone; per-port ingress enables live elsewhere
  task automatic t_sniff();
    dpsc_frame_type f;
    dpsc_verdict_type v;
    logic vld;
    for (int m = 0; m < 8; m++) begin
      wreg(ADDRS[4], 32'(m[2]));
      f = '0;
      f.src_match = m[1];
      f.dst_match = m[0];
      frame(f, v, vld);
      chk("sniff", 32'(v.sniff), 32'(m[2] ? (m[1] & m[0]) : (m[1] | m[0])));
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    t_regs();
    t_prio();
    t_reset();
    t_snoop();
    t_sniff();
    results();
  end

  initial begin
    #100000;
    n_mismatch++;
    results();
  end
endmodule // dscp_priority_snoop_ctrl_tb
`default_nettype wire
